// ===== core/wor_pkg.sv
package wor_pkg;

  // Register offsets on the plain register port
  localparam logic [5:0] ADDR_IVL_HIGH = 6'h1e;
  localparam logic [5:0] ADDR_IVL_LOW  = 6'h1f;
  localparam logic [5:0] ADDR_CTRL     = 6'h20;
  localparam logic [5:0] ADDR_STATUS   = 6'h30;

  // Reset values
  localparam logic [7:0] RST_IVL_HIGH  = 8'h87;
  localparam logic [7:0] RST_IVL_LOW   = 8'h00;
  localparam logic [7:0] RST_CTRL      = 8'hf8;

  // Control field positions
  localparam int unsigned CTRL_PD_BIT     = 7;
  localparam int unsigned CTRL_SEL_LSB    = 4;
  localparam int unsigned CTRL_CAL_BIT    = 3;
  localparam int unsigned CTRL_RSVD_BIT   = 2;
  localparam int unsigned CTRL_SCALE_LSB  = 0;

  // Status field positions
  localparam int unsigned STAT_CAL_BIT    = 0;
  localparam int unsigned STAT_RUN_BIT    = 1;

  // Timing: RC period in crystal periods, scale step and calibration length
  localparam int unsigned RC_DIV          = 750;
  localparam int unsigned SCALE_SHIFT     = 5;
  localparam int unsigned SCALE_STEPS     = 1 << SCALE_SHIFT;
  localparam int unsigned CAL_RC_PERIODS  = 4;

  typedef struct packed {
    logic       pd;
    logic [2:0] sec_sel;
    logic       cal_en;
    logic       rsvd;
    logic [1:0] scale;
  } wor_ctrl_type;

  typedef enum logic [1:0] {
    RC_OFF = 2'b00,
    RC_CLOCK_CAL_ENABLE = 2'b01,
    RC_RUN = 2'b10
  } wor_rc_state_type;

  // Secondary delay in RC periods after the primary event
  function automatic logic [5:0] wor_delay(input logic [2:0] sel);
    case (sel)
      3'h0:    wor_delay = 6'h04;
      3'h1:    wor_delay = 6'h06;
      3'h2:    wor_delay = 6'h08;
      3'h3:    wor_delay = 6'h0c;
      3'h4:    wor_delay = 6'h10;
      3'h5:    wor_delay = 6'h18;
      3'h6:    wor_delay = 6'h20;
      default: wor_delay = 6'h30;
    endcase
  endfunction

endpackage

// ===== core/wor_timer.sv
// Behaviour
// R1 - Primary period: 750 periods times interval times scale
// R2 - Interval high byte readable, writable, resets 0x87
// R3 - RC clock is crystal divided by 750
// R4 - Powerdown bit stops RC; clearing starts calibration (code calibrates only with the enable bit set, otherwise goes straight to run)
// R5 - Secondary delay select decodes 4 to 48 periods
// R6 - Calibration only runs when enable bit is set
// R7 - Scale 00 one period, 01 thirty-two periods
// R8 - Primary restarts; secondary fires after selected delay
`timescale 1ns/1ps
`default_nettype none
module wor_timer
  import wor_pkg::*;
#(
  parameter int unsigned DIV_CYCLES = RC_DIV
) (
  // Clock and reset
  input  wire  logic       CLOCK,
  input  wire  logic       RST_N,
  // Register port
  input  wire  logic [5:0] ADDR,
  input  wire  logic [7:0] WDATA,
  input  wire  logic       WR_EN,
  input  wire  logic       RD_EN,
  output logic       [7:0] RDATA,
  // Timer events and state
  output logic             PRIMARY_EVENT,
  output logic             SECONDARY_EVENT,
  output logic             RC_RUNNING,
  output logic             CAL_BUSY
);

  logic [7:0]       ivl_high_ff, nxt_ivl_high;
  logic [7:0]       ivl_low_ff, nxt_ivl_low;
  wor_ctrl_type     ctrl_ff, nxt_ctrl;
  logic [7:0]       rdata_ff, nxt_rdata;

  wor_rc_state_type state_ff, nxt_state;
  logic [9:0]       div_ff, nxt_div;
  logic             tick_ff, nxt_tick;
  logic [2:0]       cal_cnt_ff, nxt_cal_cnt;
  logic [4:0]       sub_ff, nxt_sub;
  logic [15:0]      main_ff, nxt_main;
  logic             sec_act_ff, nxt_sec_act;
  logic [5:0]       sec_cnt_ff, nxt_sec_cnt;
  logic             prim_ff, nxt_prim;
  logic             sec_ff, nxt_sec;
  logic             run_ff, nxt_run;
  logic             cal_ff, nxt_cal;

  logic [15:0]      ivl;
  logic [15:0]      ivl_last;
  logic             step;
  logic             hit;

  function automatic logic [7:0] reg_read(input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_IVL_HIGH: v = ivl_high_ff;
      ADDR_IVL_LOW:  v = ivl_low_ff;
      ADDR_CTRL:     v = ctrl_ff;
      ADDR_STATUS: begin
        v[STAT_CAL_BIT] = (state_ff == RC_CLOCK_CAL_ENABLE);
        v[STAT_RUN_BIT] = (state_ff == RC_RUN);
      end
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  // Register file
  always_comb begin
    nxt_ivl_high = ivl_high_ff;
    nxt_ivl_low  = ivl_low_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_rdata    = 8'h00;
    if (WR_EN) begin
      case (ADDR)
        ADDR_IVL_HIGH: nxt_ivl_high = WDATA; // R2
        ADDR_IVL_LOW:  nxt_ivl_low  = WDATA;
        ADDR_CTRL: begin
          nxt_ctrl      = wor_ctrl_type'(WDATA);
          nxt_ctrl.rsvd = 1'b0;
        end
        default: ;
      endcase
    end
    if (RD_EN) begin
      nxt_rdata = reg_read(ADDR);
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ivl_high_ff <= RST_IVL_HIGH; // R2
      ivl_low_ff  <= RST_IVL_LOW;
      ctrl_ff     <= wor_ctrl_type'(RST_CTRL);
      rdata_ff    <= 8'h00;
    end else begin
      ivl_high_ff <= nxt_ivl_high;
      ivl_low_ff  <= nxt_ivl_low;
      ctrl_ff     <= nxt_ctrl;
      rdata_ff    <= nxt_rdata;
    end
  end

  // A zero interval would wrap to 0xFFFF and match only after 65536 steps; it runs as one LSB instead
  assign ivl      = {ivl_high_ff, ivl_low_ff};
  assign ivl_last = (ivl == 16'h0000) ? 16'h0000 : ivl - 16'h0001;
  // Scale 10 and 11 are unsupported; only the low bit is decoded
  assign step     = !ctrl_ff.scale[0] || (sub_ff == 5'(SCALE_STEPS - 1)); // R7
  assign hit      = step && (main_ff >= ivl_last); // R1

  // RC clock, calibration and wake counters
  always_comb begin
    nxt_state   = state_ff;
    nxt_div     = 10'h000;
    nxt_tick    = 1'b0;
    nxt_cal_cnt = cal_cnt_ff;
    nxt_sub     = sub_ff;
    nxt_main    = main_ff;
    nxt_sec_act = sec_act_ff;
    nxt_sec_cnt = sec_cnt_ff;
    nxt_prim    = 1'b0;
    nxt_sec     = 1'b0;
    // Gate on the control bit too, so the divider is already idle when the state drops
    if (state_ff != RC_OFF && !ctrl_ff.pd) begin
      if (div_ff == 10'(DIV_CYCLES - 1)) begin
        nxt_tick = 1'b1; // R3
      end else begin
        nxt_div = div_ff + 10'h001;
      end
    end
    case (state_ff)
      RC_OFF: begin
        nxt_cal_cnt = 3'h0;
        if (!ctrl_ff.pd) begin
          nxt_state = ctrl_ff.cal_en ? RC_CLOCK_CAL_ENABLE : RC_RUN; // R4 R6
        end
      end
      RC_CLOCK_CAL_ENABLE: begin
        if (ctrl_ff.pd) begin
          nxt_state = RC_OFF; // R4
        end else if (tick_ff) begin
          nxt_cal_cnt = cal_cnt_ff + 3'h1;
          if (cal_cnt_ff == 3'(CAL_RC_PERIODS - 1)) begin
            nxt_state = RC_RUN;
          end
        end
      end
      RC_RUN: begin
        if (ctrl_ff.pd) begin
          nxt_state = RC_OFF; // R4
        end else if (tick_ff) begin
          nxt_sub = ctrl_ff.scale[0] ? sub_ff + 5'h01 : 5'h00; // R7
          if (hit) begin
            nxt_main    = 16'h0000; // R8
            nxt_prim    = 1'b1;
            nxt_sec_act = 1'b1;
            nxt_sec_cnt = 6'h00;
          end else if (step) begin
            nxt_main = main_ff + 16'h0001; // R1
          end
          if (sec_act_ff && !hit) begin
            if (sec_cnt_ff == wor_delay(ctrl_ff.sec_sel) - 6'h01) begin
              nxt_sec     = 1'b1; // R5
              nxt_sec_act = 1'b0;
            end else begin
              nxt_sec_cnt = sec_cnt_ff + 6'h01;
            end
          end
        end
      end
      default: nxt_state = RC_OFF;
    endcase
    if (nxt_state != RC_RUN) begin
      nxt_sub     = 5'h00;
      nxt_main    = 16'h0000;
      nxt_sec_act = 1'b0;
      nxt_sec_cnt = 6'h00;
    end
    // Status outputs are registered copies of the next state, so they match its decode
    nxt_run = (nxt_state == RC_RUN);
    nxt_cal = (nxt_state == RC_CLOCK_CAL_ENABLE);
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff   <= RC_OFF;
      run_ff     <= 1'b0;
      cal_ff     <= 1'b0;
      div_ff     <= 10'h000;
      tick_ff    <= 1'b0;
      cal_cnt_ff <= 3'h0;
      sub_ff     <= 5'h00;
      main_ff    <= 16'h0000;
      sec_act_ff <= 1'b0;
      sec_cnt_ff <= 6'h00;
      prim_ff    <= 1'b0;
      sec_ff     <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      div_ff     <= nxt_div;
      tick_ff    <= nxt_tick;
      cal_cnt_ff <= nxt_cal_cnt;
      sub_ff     <= nxt_sub;
      main_ff    <= nxt_main;
      sec_act_ff <= nxt_sec_act;
      sec_cnt_ff <= nxt_sec_cnt;
      prim_ff    <= nxt_prim;
      sec_ff     <= nxt_sec;
      run_ff     <= nxt_run;
      cal_ff     <= nxt_cal;
    end
  end

  assign RDATA           = rdata_ff;
  assign PRIMARY_EVENT   = prim_ff;
  assign SECONDARY_EVENT = sec_ff;
  assign RC_RUNNING      = run_ff;
  assign CAL_BUSY        = cal_ff;

  property p_rc_div;
    @(posedge CLOCK) disable iff (!RST_N)
      tick_ff |-> $past(div_ff) == 10'(DIV_CYCLES - 1);
  endproperty
  a_rc_div: assert property (p_rc_div) else $error("RC tick off divider end"); // R3

  property p_pd_stops;
    @(posedge CLOCK) disable iff (!RST_N)
      ctrl_ff.pd ##1 ctrl_ff.pd |-> state_ff == RC_OFF && !tick_ff && div_ff == 10'h000;
  endproperty
  a_pd_stops: assert property (p_pd_stops) else $error("RC runs while powered down"); // R4

  property p_high_write;
    @(posedge CLOCK) disable iff (!RST_N)
      WR_EN && ADDR == ADDR_IVL_HIGH ##1 !WR_EN ##1 RD_EN && ADDR == ADDR_IVL_HIGH
        |=> RDATA == $past(WDATA, 3);
  endproperty
  a_high_write: assert property (p_high_write) else $error("High byte readback wrong"); // R2

  property p_cal_start;
    @(posedge CLOCK) disable iff (!RST_N)
      state_ff == RC_OFF && WR_EN && ADDR == ADDR_CTRL
        && !WDATA[CTRL_PD_BIT] && WDATA[CTRL_CAL_BIT] |-> ##2 CAL_BUSY;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("Calibration not started"); // R4

  property p_cal_skip;
    @(posedge CLOCK) disable iff (!RST_N)
      $rose(state_ff != RC_OFF) && !$past(ctrl_ff.cal_en) |-> state_ff == RC_RUN;
  endproperty
  a_cal_skip: assert property (p_cal_skip) else $error("Calibration ran while disabled"); // R6

  property p_sec_delay;
    @(posedge CLOCK) disable iff (!RST_N)
      sec_ff |-> $past(tick_ff)
        && $past(sec_cnt_ff) == wor_delay($past(ctrl_ff.sec_sel)) - 6'h01;
  endproperty
  a_sec_delay: assert property (p_sec_delay) else $error("Secondary delay wrong"); // R5

  property p_scale;
    @(posedge CLOCK) disable iff (!RST_N)
      prim_ff && $past(ctrl_ff.scale[0]) |-> $past(sub_ff) == 5'(SCALE_STEPS - 1);
  endproperty
  a_scale: assert property (p_scale) else $error("Primary event inside a scale step"); // R7

  property p_prim_period;
    @(posedge CLOCK) disable iff (!RST_N)
      prim_ff |-> $past(tick_ff) && $past(main_ff) >= $past(ivl_last) && main_ff == 16'h0000;
  endproperty
  a_prim_period: assert property (p_prim_period) else $error("Primary event early"); // R1

  property p_restart;
    @(posedge CLOCK) disable iff (!RST_N)
      prim_ff && RC_RUNNING |-> sec_act_ff && sec_cnt_ff == 6'h00 && !sec_ff;
  endproperty
  a_restart: assert property (p_restart) else $error("Secondary not restarted"); // R8

endmodule // wor_timer
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wor_pkg::*;
  localparam int DIV = 4;
  logic       CLOCK;
  logic       RST_N;
  logic [5:0] ADDR;
  logic [7:0] WDATA;
  logic       WR_EN;
  logic       RD_EN;
  logic [7:0] RDATA;
  logic       PRIMARY_EVENT;
  logic       SECONDARY_EVENT;
  logic       RC_RUNNING;
  logic       CAL_BUSY;
  int         failures = 0;
  int         total_checks = 0;
  int         mdl [int];
  int         n;
  logic [7:0] lo;
  int         dly [8] = '{4, 6, 8, 12, 16, 24, 32, 48};

  wor_timer #(.DIV_CYCLES(DIV)) u_dut (
    .CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA),
    .PRIMARY_EVENT(PRIMARY_EVENT), .SECONDARY_EVENT(SECONDARY_EVENT),
    .RC_RUNNING(RC_RUNNING), .CAL_BUSY(CAL_BUSY)
  );

  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Model keeps the readable image; the reserved control bit never sticks
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR_EN <= 1'b1;
    @(posedge CLOCK);
    WR_EN <= 1'b0;
    if (a == ADDR_IVL_HIGH || a == ADDR_IVL_LOW) mdl[a] = d;
    if (a == ADDR_CTRL) mdl[a] = d & 8'hfb;
  endtask

  task automatic rd_chk(input logic [5:0] a);
    @(posedge CLOCK);
    ADDR <= a;
    RD_EN <= 1'b1;
    @(posedge CLOCK);
    RD_EN <= 1'b0;
    #1;
    chk("rdata", mdl.exists(a) ? 16'(mdl[a]) : 16'h0000, {8'h00, RDATA});
    @(posedge CLOCK);
    #1;
    chk("rdata idle", 16'h0000, {8'h00, RDATA});
  endtask

  // Waits for a primary event, then counts cycles to the next chosen event
  task automatic gap(input logic sec, output int cnt);
    int k;
    k = 0;
    while (PRIMARY_EVENT !== 1'b1 && k < 20000) begin
      @(posedge CLOCK);
      #1;
      k++;
    end
    cnt = 0;
    do begin
      @(posedge CLOCK);
      #1;
      cnt++;
    end while ((sec ? SECONDARY_EVENT : PRIMARY_EVENT) !== 1'b1 && cnt < 20000);
    if (k >= 20000 || cnt >= 20000) begin
      failures++;
      give_verdict();
    end
  endtask

  initial begin
    void'($urandom(32'h9412));
    RST_N = 1'b0;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR = 6'h00;
    WDATA = 8'h00;
    mdl[ADDR_IVL_HIGH] = 8'h87;
    mdl[ADDR_IVL_LOW] = 8'h00;
    mdl[ADDR_CTRL] = {1'b1, 3'h7, 1'b1, 1'b0, 2'h0};
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    rd_chk(ADDR_IVL_HIGH);
    rd_chk(ADDR_CTRL);
    rd_chk(6'h3f);
    chk("running", 16'h0000, {15'h0000, RC_RUNNING});
    lo = 8'($urandom);
    wr(ADDR_IVL_HIGH, lo);
    rd_chk(ADDR_IVL_HIGH);
    wr(ADDR_CTRL, 8'hfc);
    rd_chk(ADDR_CTRL);
    wr(6'h3f, 8'h55);
    rd_chk(6'h3f);
    $display("done: registers");
    lo = 8'(2 + $urandom % 5);
    wr(ADDR_IVL_HIGH, 8'h00);
    wr(ADDR_IVL_LOW, lo);
    wr(ADDR_CTRL, 8'h08);
    @(posedge CLOCK);
    #1;
    chk("cal busy", 16'h0001, {15'h0000, CAL_BUSY});
    mdl[ADDR_STATUS] = 8'h01;
    rd_chk(ADDR_STATUS);
    n = 0;
    while (RC_RUNNING !== 1'b1 && n < 8 * DIV + 4) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    chk("run after cal", 16'h0001, {15'h0000, RC_RUNNING});
    gap(1'b0, n);
    gap(1'b0, n);
    chk("period x1", 16'(lo * DIV), 16'(n));
    wr(ADDR_IVL_LOW, 8'h01);
    wr(ADDR_CTRL, 8'h01);
    gap(1'b0, n);
    gap(1'b0, n);
    chk("period x32", 16'(32 * DIV), 16'(n));
    $display("done: primary");
    wr(ADDR_IVL_LOW, 8'h3c);
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_CTRL, {1'b0, 3'(s), 4'h0});
      gap(1'b1, n);
      gap(1'b1, n);
      chk("secondary", 16'(dly[s] * DIV), 16'(n));
    end
    $display("done: secondary");
    wr(ADDR_CTRL, 8'h80);
    repeat (3) @(posedge CLOCK);
    #1;
    chk("stopped", 16'h0000, {15'h0000, RC_RUNNING});
    n = 0;
    repeat (300) begin
      @(posedge CLOCK);
      #1;
      n += int'(PRIMARY_EVENT !== 1'b0);
    end
    chk("idle events", 16'h0000, 16'(n));
    wr(ADDR_CTRL, 8'h00);
    @(posedge CLOCK);
    #1;
    chk("run no cal", 16'h0001, {15'h0000, RC_RUNNING});
    chk("no cal", 16'h0000, {15'h0000, CAL_BUSY});
    mdl[ADDR_STATUS] = 8'h02;
    wr(ADDR_STATUS, 8'hff);
    rd_chk(ADDR_STATUS);
    $display("done: power and calibration");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
